// ===== tcs_pkg.sv
// Shared constants and types for the terminal cursor sequencer
package tcs_pkg;
   // Register byte offsets
   localparam logic [7:0] TCS_CMD_OFS = 8'h00;
   localparam logic [7:0] TCS_CTRL_OFS = 8'h04;
   localparam logic [7:0] TCS_DIV_OFS = 8'h08;
   localparam logic [7:0] TCS_STAT_OFS = 8'h0c;
   localparam logic [7:0] TCS_SAVE_OFS = 8'h10;
   // Command word bit positions
   localparam int TCS_C_ROW_UP = 0;
   localparam int TCS_C_COL_UP = 1;
   localparam int TCS_C_ROW_DN = 2;
   localparam int TCS_C_COL_DN = 3;
   localparam int TCS_C_ROW_LD = 4;
   localparam int TCS_C_COL_LD = 5;
   localparam int TCS_C_SAVE = 6;
   localparam int TCS_C_SCROLL = 7;
   localparam int TCS_C_OP_LD = 8;
   localparam int TCS_C_STEP_LD = 9;
   localparam int TCS_C_BUS_SEL = 10;
   localparam int TCS_C_TX_LD = 11;
   localparam int TCS_C_IDLE = 12;
   localparam int TCS_C_STEP = 13;
   localparam int TCS_C_WRITE = 14;
   localparam int TCS_C_ARG_LSB = 16;
   localparam int TCS_CMD_W = 15;
   // Control register bit positions
   localparam int TCS_K_LOCK = 0;
   localparam int TCS_K_INS = 1;
   localparam int TCS_K_LOCAL = 2;
   localparam int TCS_K_AUX = 3;
   // Bus sources
   localparam logic [2:0] TCS_SRC_INBUF = 3'h0;
   localparam logic [2:0] TCS_SRC_MEM = 3'h1;
   localparam logic [2:0] TCS_SRC_DELIM = 3'h2;
   localparam logic [2:0] TCS_SRC_INSDEL = 3'h3;
   localparam logic [2:0] TCS_SRC_KEY = 3'h4;
   // Geometry and counts
   localparam logic [4:0] TCS_ROW_MAX = 5'h17;
   localparam logic [6:0] TCS_COL_MAX = 7'h4f;
   localparam logic [4:0] TCS_SCROLL_WRAP = 5'h17;
   localparam logic [10:0] TCS_LINE_CHARS = 11'h050;
   localparam logic [6:0] TCS_PRESET_BIAS = 7'h20;
   localparam logic [3:0] TCS_LAST_CODE = 4'hf;
   localparam logic [3:0] TCS_X16 = 4'hf;
   localparam logic [1:0] TCS_STB_LAST = 2'h3;
   // Reset values
   localparam logic [15:0] TCS_MDIV_RST = 16'h0010;
   localparam logic [15:0] TCS_ADIV_RST = 16'h0010;
   localparam logic [3:0] TCS_CTRL_RST = 4'h0;
   typedef enum logic [1:0] {TCS_IDLE = 2'b01, TCS_OPER = 2'b10} tcs_mode_t;
endpackage

// ===== tcs_core.sv
// Terminal cursor sequencer core with APB register slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module tcs_core
   import tcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic keypad_full_reset,
   input wire logic [6:0] inbuf_char,
   input wire logic [6:0] mem_char,
   input wire logic [6:0] delim_char,
   input wire logic [6:0] insdel_char,
   input wire logic [6:0] key_char,
   input wire logic tx_taken,
   output logic [6:0] tx_char,
   output logic tx_hold_occupied,
   output logic [6:0] mem_wdata,
   output logic mem_write,
   output logic mem_insert,
   output logic [10:0] display_base,
   output logic [3:0] operation_code_bits,
   output logic op_code_15,
   output logic main_timing_pulse,
   output logic primary_serial_clock_x16,
   output logic aux_serial_clock_x16,
   output logic selected_serial_clock,
   output logic baud_tick
);
   typedef struct packed {
      logic [1:0] stb_cnt;
      logic stb;
      logic [15:0] mcnt;
      logic [15:0] acnt;
      logic [3:0] bcnt;
      logic mx16;
      logic ax16;
      logic sx16;
      logic btick;
      tcs_mode_t mode;
      logic [3:0] op;
      logic [3:0] step;
      logic [4:0] row;
      logic [6:0] col;
      logic [4:0] srow;
      logic [6:0] scol;
      logic [4:0] scroll;
      logic [10:0] base;
      logic [2:0] bsel;
      logic [3:0] ctrl;
      logic [15:0] mdiv;
      logic [15:0] adiv;
      logic pend;
      logic [TCS_CMD_W-1:0] cmd;
      logic [3:0] arg;
      logic hold;
      logic [6:0] txd;
      logic wr;
      logic ins;
      logic [6:0] wdata;
      logic [31:0] rdata;
      logic err;
   } tcs_state_t;

   tcs_state_t st_ff;
   tcs_state_t nxt_st;
   logic [6:0] bus;
   logic [6:0] bias;
   logic acc;
   logic hit;
   logic stall;

   // Keyboard reads as a null while locked out, so nothing reaches the line; memory writes store the null
   // Single bus driver
   always_comb begin
      unique case (st_ff.bsel)
         TCS_SRC_INBUF: bus = inbuf_char;
         TCS_SRC_MEM: bus = mem_char;
         TCS_SRC_DELIM: bus = delim_char;
         TCS_SRC_INSDEL: bus = insdel_char;
         TCS_SRC_KEY: bus = st_ff.ctrl[TCS_K_LOCK] ? 7'h00 : key_char;
         default: bus = 7'h00;
      endcase
   end

   assign bias = bus - TCS_PRESET_BIAS;
   assign acc = psel & penable;
   assign hit = (paddr == TCS_CMD_OFS) || (paddr == TCS_CTRL_OFS) ||
                (paddr == TCS_DIV_OFS) || (paddr == TCS_STAT_OFS) ||
                (paddr == TCS_SAVE_OFS);
   // A new command waits until the previous one has been executed
   assign stall = pwrite & (paddr == TCS_CMD_OFS) & st_ff.pend;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.wr = 1'b0;
      nxt_st.ins = 1'b0;
      nxt_st.btick = 1'b0;
      nxt_st.stb_cnt = st_ff.stb_cnt + 2'h1;
      nxt_st.stb = (st_ff.stb_cnt == TCS_STB_LAST);
      nxt_st.mx16 = 1'b0;
      nxt_st.ax16 = 1'b0;
      nxt_st.mcnt = st_ff.mcnt + 16'h0001;
      if (st_ff.mcnt >= st_ff.mdiv - 16'h0001) begin
         nxt_st.mcnt = 16'h0000;
         nxt_st.mx16 = 1'b1;
      end
      nxt_st.acnt = st_ff.acnt + 16'h0001;
      if (st_ff.acnt >= st_ff.adiv - 16'h0001) begin
         nxt_st.acnt = 16'h0000;
         nxt_st.ax16 = 1'b1;
      end
      nxt_st.sx16 = st_ff.ctrl[TCS_K_AUX] ? nxt_st.ax16 : nxt_st.mx16;
      if (nxt_st.sx16) begin
         nxt_st.bcnt = st_ff.bcnt + 4'h1;
         nxt_st.btick = (st_ff.bcnt == TCS_X16);
      end
      if (tx_taken) begin
         nxt_st.hold = 1'b0;
      end
      // Commands execute on the main pulse only
      if (st_ff.stb && st_ff.pend) begin
         nxt_st.pend = 1'b0;
         if (st_ff.cmd[TCS_C_ROW_UP]) begin
            nxt_st.row = (st_ff.row == TCS_ROW_MAX) ? 5'h00 : st_ff.row + 5'h01;
         end else if (st_ff.cmd[TCS_C_ROW_DN]) begin
            nxt_st.row = (st_ff.row == 5'h00) ? TCS_ROW_MAX : st_ff.row - 5'h01;
         end else if (st_ff.cmd[TCS_C_ROW_LD]) begin
            nxt_st.row = (bias[4:0] > TCS_ROW_MAX || bias > 7'h1f) ?
                         TCS_ROW_MAX : bias[4:0];
         end
         if (st_ff.cmd[TCS_C_COL_UP]) begin
            nxt_st.col = (st_ff.col == TCS_COL_MAX) ? 7'h00 : st_ff.col + 7'h01;
         end else if (st_ff.cmd[TCS_C_COL_DN]) begin
            nxt_st.col = (st_ff.col == 7'h00) ? TCS_COL_MAX : st_ff.col - 7'h01;
         end else if (st_ff.cmd[TCS_C_COL_LD]) begin
            nxt_st.col = (bias > TCS_COL_MAX) ? TCS_COL_MAX : bias;
         end
         if (st_ff.cmd[TCS_C_SAVE]) begin
            nxt_st.srow = st_ff.row;
            nxt_st.scol = st_ff.col;
         end
         if (st_ff.cmd[TCS_C_SCROLL]) begin
            nxt_st.scroll = (st_ff.scroll + 5'h01 == TCS_SCROLL_WRAP) ? 5'h00 :
                            st_ff.scroll + 5'h01;
            // One line of 80 characters per step
            nxt_st.base = (st_ff.scroll + 5'h01 == TCS_SCROLL_WRAP) ? 11'h000 :
                          st_ff.base + TCS_LINE_CHARS;
         end
         if (st_ff.cmd[TCS_C_STEP]) begin
            nxt_st.step = (st_ff.step == TCS_LAST_CODE - 4'h1) ? 4'h0 :
                          st_ff.step + 4'h1;
         end
         if (st_ff.cmd[TCS_C_STEP_LD] && st_ff.arg != TCS_LAST_CODE) begin
            nxt_st.step = st_ff.arg;
         end
         if (st_ff.cmd[TCS_C_OP_LD] && st_ff.arg != TCS_LAST_CODE) begin
            nxt_st.op = st_ff.arg;
            nxt_st.mode = TCS_OPER;
         end else if (st_ff.cmd[TCS_C_IDLE]) begin
            nxt_st.mode = TCS_IDLE;
         end
         if (st_ff.cmd[TCS_C_BUS_SEL]) begin
            nxt_st.bsel = st_ff.arg[2:0];
         end
         // Null filter; local-only blocks the line
         if (st_ff.cmd[TCS_C_TX_LD] && bus != 7'h00 && !st_ff.ctrl[TCS_K_LOCAL]) begin
            nxt_st.hold = 1'b1;
            nxt_st.txd = bus;
         end
         if (st_ff.cmd[TCS_C_WRITE]) begin
            nxt_st.wr = !st_ff.ctrl[TCS_K_INS];
            nxt_st.ins = st_ff.ctrl[TCS_K_INS];
            nxt_st.wdata = bus;
         end
      end
      // APB: read data captured in setup, writes take effect at the access edge
      if (psel && !penable) begin
         nxt_st.err = !hit;
         unique case (paddr)
            TCS_CTRL_OFS: nxt_st.rdata = {28'h0000000, st_ff.ctrl};
            TCS_DIV_OFS: nxt_st.rdata = {st_ff.adiv, st_ff.mdiv};
            TCS_STAT_OFS: nxt_st.rdata = {4'h0, st_ff.pend, st_ff.hold,
                                         st_ff.mode, st_ff.step, st_ff.op,
                                         1'b0, st_ff.col, 3'h0, st_ff.row};
            TCS_SAVE_OFS: nxt_st.rdata = {11'h000, st_ff.scroll, 1'b0,
                                         st_ff.scol, 3'h0, st_ff.srow};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end
      if (acc && pwrite && !stall) begin
         unique case (paddr)
            TCS_CMD_OFS: begin
               nxt_st.cmd = pwdata[TCS_CMD_W-1:0];
               nxt_st.arg = pwdata[TCS_C_ARG_LSB+3:TCS_C_ARG_LSB];
               nxt_st.pend = |pwdata[TCS_CMD_W-1:0];
            end
            TCS_CTRL_OFS: nxt_st.ctrl = pwdata[3:0];
            TCS_DIV_OFS: begin
               nxt_st.mdiv = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
               nxt_st.adiv = (pwdata[31:16] == 16'h0000) ? 16'h0001 : pwdata[31:16];
            end
            default: ;
         endcase
      end
      // Keypad full reset clears the terminal functions except the clock divisors
      if (keypad_full_reset) begin
         nxt_st.mode = TCS_IDLE;
         nxt_st.op = 4'h0;
         nxt_st.step = 4'h0;
         nxt_st.row = 5'h00;
         nxt_st.col = 7'h00;
         nxt_st.srow = 5'h00;
         nxt_st.scol = 7'h00;
         nxt_st.scroll = 5'h00;
         nxt_st.base = 11'h000;
         nxt_st.bsel = TCS_SRC_INBUF;
         nxt_st.ctrl = TCS_CTRL_RST;
         nxt_st.pend = 1'b0;
         nxt_st.hold = 1'b0;
         nxt_st.wr = 1'b0;
         nxt_st.ins = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.mode <= TCS_IDLE;
         st_ff.mdiv <= TCS_MDIV_RST;
         st_ff.adiv <= TCS_ADIV_RST;
         st_ff.ctrl <= TCS_CTRL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.rdata;
   assign pready = !stall;
   assign pslverr = st_ff.err & acc;
   assign tx_char = st_ff.txd;
   assign tx_hold_occupied = st_ff.hold;
   assign mem_wdata = st_ff.wdata;
   assign mem_write = st_ff.wr;
   assign mem_insert = st_ff.ins;
   assign display_base = st_ff.base;
   // Binary weights 1, 2, 4, 8 on lines 1 to 4
   assign operation_code_bits = st_ff.op;
   // All lines high is operation 15
   assign op_code_15 = &st_ff.op;
   assign main_timing_pulse = st_ff.stb;
   assign primary_serial_clock_x16 = st_ff.mx16;
   assign aux_serial_clock_x16 = st_ff.ax16;
   assign selected_serial_clock = st_ff.sx16;
   assign baud_tick = st_ff.btick;

   chk_base_scroll: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.base == 11'(st_ff.scroll) * TCS_LINE_CHARS)
      else $error("display base does not track scroll");
   chk_scroll_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.scroll < TCS_SCROLL_WRAP)
      else $error("scroll counter reached 23");
   chk_row_range: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.row <= TCS_ROW_MAX)
      else $error("cursor row out of range");
   chk_col_range: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.col <= TCS_COL_MAX)
      else $error("cursor column out of range");
   chk_row_up: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_ROW_UP] && !keypad_full_reset &&
      st_ff.row < TCS_ROW_MAX |=> st_ff.row == $past(st_ff.row) + 5'h01)
      else $error("row did not count up");
   chk_col_up: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_COL_UP] && !keypad_full_reset &&
      st_ff.col < TCS_COL_MAX |=> st_ff.col == $past(st_ff.col) + 7'h01)
      else $error("column did not count up");
   chk_null_block: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_ff.hold) |-> st_ff.txd != 7'h00)
      else $error("null character loaded for transmit");
   chk_local_only: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.ctrl[TCS_K_LOCAL] && !st_ff.hold |=> !$rose(st_ff.hold))
      else $error("local-only character sent");
   chk_write_strobe: assert property (@(posedge pclk) disable iff (!presetn)
      (mem_write || mem_insert) |-> $past(st_ff.stb))
      else $error("memory write not timed to main pulse");
   chk_idle_reset: assert property (@(posedge pclk) disable iff (!presetn)
      keypad_full_reset |=> st_ff.mode == TCS_IDLE && st_ff.row == 5'h00 &&
      st_ff.col == 7'h00 && st_ff.scroll == 5'h00 && st_ff.op == 4'h0)
      else $error("full reset left state behind");
   chk_op_all_high: assert property (@(posedge pclk) disable iff (!presetn)
      op_code_15 == (st_ff.op == TCS_LAST_CODE))
      else $error("operation 15 decode wrong");
   chk_op_preset: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_OP_LD] && st_ff.arg != TCS_LAST_CODE &&
      !keypad_full_reset |=> st_ff.op == $past(st_ff.arg) && st_ff.mode == TCS_OPER)
      else $error("operation preset not taken");
   chk_step_preset: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_STEP_LD] && st_ff.arg != TCS_LAST_CODE &&
      !keypad_full_reset |=> st_ff.step == $past(st_ff.arg))
      else $error("step preset not taken");
   chk_step_range: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.step != TCS_LAST_CODE)
      else $error("sequence step out of range");
   chk_row_preset: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_ROW_LD] && !st_ff.cmd[TCS_C_ROW_UP] &&
      !st_ff.cmd[TCS_C_ROW_DN] && !keypad_full_reset && bias <= {2'b00, TCS_ROW_MAX}
      |=> {2'b00, st_ff.row} == $past(bias))
      else $error("row preset did not take the bus");
   chk_col_preset: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_COL_LD] && !st_ff.cmd[TCS_C_COL_UP] &&
      !st_ff.cmd[TCS_C_COL_DN] && !keypad_full_reset && bias <= TCS_COL_MAX
      |=> st_ff.col == $past(bias))
      else $error("column preset did not take the bus");
   chk_save_copy: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_SAVE] && !keypad_full_reset
      |=> st_ff.srow == $past(st_ff.row) && st_ff.scol == $past(st_ff.col))
      else $error("saved cursor not copied");
   chk_hold_clear: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.hold && tx_taken && !(st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_TX_LD])
      |=> !tx_hold_occupied)
      else $error("holding flag stayed after take");
   chk_insert_sel: assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.stb && st_ff.pend && st_ff.cmd[TCS_C_WRITE] && !keypad_full_reset
      |=> mem_insert == $past(st_ff.ctrl[TCS_K_INS]) && mem_write != mem_insert)
      else $error("insert or overwrite chosen wrongly");
   chk_sel_clock: assert property (@(posedge pclk) disable iff (!presetn)
      selected_serial_clock |-> primary_serial_clock_x16 || aux_serial_clock_x16)
      else $error("selected clock from neither port");
   chk_baud_tick: assert property (@(posedge pclk) disable iff (!presetn)
      baud_tick |-> selected_serial_clock)
      else $error("baud tick off the selected clock");
endmodule // tcs_core

// ===== tcs_far_model.sv
// Far-side model: serial transmitter that drains the holding character, memory observer
`timescale 1ns/10ps
module tcs_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic tx_hold_occupied,
   input wire logic mem_write,
   input wire logic mem_insert,
   input wire logic [6:0] mem_wdata,
   output logic tx_taken,
   output int writes_seen,
   output int inserts_seen,
   output logic [6:0] last_wdata
);
   int wait_cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_taken <= 1'b0;
         wait_cnt <= 0;
         writes_seen <= 0;
         inserts_seen <= 0;
         last_wdata <= 7'h00;
      end else begin
         tx_taken <= 1'b0;
         wait_cnt <= tx_hold_occupied ? wait_cnt + 1 : 0;
         // drain held character
         // Slow mode lets the bench see the occupied flag before it drops
         if (tx_hold_occupied && !tx_taken && wait_cnt >= (slow ? 30 : 2)) begin
            tx_taken <= 1'b1;
            wait_cnt <= 0;
         end
         if (mem_write || mem_insert) begin
            last_wdata <= mem_wdata;
         end
         if (mem_write) begin
            writes_seen <= writes_seen + 1;
         end
         if (mem_insert) begin
            inserts_seen <= inserts_seen + 1;
         end
      end
   end
endmodule // tcs_far_model

// ===== testbench.sv
// Self-checking bench for the terminal cursor sequencer
`timescale 1ns/10ps
module testbench
   import tcs_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, keypad_full_reset, far_slow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] inbuf_char, mem_char, delim_char, insdel_char, key_char, tx_char, mem_wdata;
   logic [6:0] last_wdata;
   logic tx_taken, tx_hold_occupied, mem_write, mem_insert, op_code_15, main_timing_pulse;
   logic primary_serial_clock_x16, aux_serial_clock_x16, selected_serial_clock, baud_tick;
   logic [10:0] display_base;
   logic [3:0] operation_code_bits;
   logic er;
   int fail_count, samples_checked, writes_seen, inserts_seen, w0, i0;
   int n_main, n_pri, n_aux, n_sel, n_baud;

   tcs_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .keypad_full_reset(keypad_full_reset), .inbuf_char(inbuf_char),
      .mem_char(mem_char), .delim_char(delim_char), .insdel_char(insdel_char),
      .key_char(key_char), .tx_taken(tx_taken), .tx_char(tx_char),
      .tx_hold_occupied(tx_hold_occupied), .mem_wdata(mem_wdata), .mem_write(mem_write),
      .mem_insert(mem_insert), .display_base(display_base),
      .operation_code_bits(operation_code_bits), .op_code_15(op_code_15),
      .main_timing_pulse(main_timing_pulse),
      .primary_serial_clock_x16(primary_serial_clock_x16),
      .aux_serial_clock_x16(aux_serial_clock_x16),
      .selected_serial_clock(selected_serial_clock), .baud_tick(baud_tick));

   tcs_far_model far (.pclk(pclk), .presetn(presetn), .slow(far_slow),
      .tx_hold_occupied(tx_hold_occupied), .mem_write(mem_write), .mem_insert(mem_insert),
      .mem_wdata(mem_wdata), .tx_taken(tx_taken), .writes_seen(writes_seen),
      .inserts_seen(inserts_seen), .last_wdata(last_wdata));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task close_out;
      if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held from setup until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) fail_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Issue one command and wait until the main pulse has executed it
   task cmd(input int b, input logic [3:0] arg);
      int n;
      apb(1'b1, TCS_CMD_OFS, (32'h1 << b) | {12'h000, arg, 16'h0000});
      n = 0;
      do begin
         apb(1'b0, TCS_STAT_OFS, 32'h0);
         n++;
      end while (rd[27] !== 1'b0 && n < 20);
      if (n >= 20) fail_count++;
   endtask

   task sel(input logic [2:0] s);
      cmd(TCS_C_BUS_SEL, {1'b0, s});
   endtask

   task count(input int cyc);
      {n_main, n_pri, n_aux, n_sel, n_baud} = '0;
      repeat (cyc) begin
         @(posedge pclk);
         #1;
         n_main += int'(main_timing_pulse === 1'b1);
         n_pri += int'(primary_serial_clock_x16 === 1'b1);
         n_aux += int'(aux_serial_clock_x16 === 1'b1);
         n_sel += int'(selected_serial_clock === 1'b1);
         n_baud += int'(baud_tick === 1'b1);
      end
   endtask

   task t_reset;
      apb(1'b0, TCS_STAT_OFS, 32'h0);
      chk(rd, 32'h0100_0000);
      apb(1'b0, TCS_DIV_OFS, 32'h0);
      chk(rd, 32'h0010_0010);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
   endtask

   task t_cursor;
      inbuf_char <= 7'h25;
      sel(TCS_SRC_INBUF);
      cmd(TCS_C_ROW_LD, 4'h0);
      mem_char <= 7'h6f;
      sel(TCS_SRC_MEM);
      cmd(TCS_C_COL_LD, 4'h0);
      chk(32'(rd[4:0]), 32'h5);
      chk(32'(rd[14:8]), 32'h4f);
      cmd(TCS_C_ROW_UP, 4'h0);
      cmd(TCS_C_COL_UP, 4'h0);
      cmd(TCS_C_SAVE, 4'h0);
      apb(1'b0, TCS_SAVE_OFS, 32'h0);
      chk(32'(rd[4:0]), 32'h6);
      chk(32'(rd[14:8]), 32'h0);
      delim_char <= 7'h37;
      sel(TCS_SRC_DELIM);
      cmd(TCS_C_ROW_LD, 4'h0);
      cmd(TCS_C_ROW_UP, 4'h0);
      chk(32'(rd[4:0]), 32'h0);
      cmd(TCS_C_ROW_DN, 4'h0);
      chk(32'(rd[4:0]), 32'h17);
      insdel_char <= 7'h20;
      sel(TCS_SRC_INSDEL);
      cmd(TCS_C_COL_LD, 4'h0);
      cmd(TCS_C_COL_DN, 4'h0);
      chk(32'(rd[14:8]), 32'h4f);
   endtask

   task t_scroll;
      for (int i = 1; i <= 23; i++) begin
         cmd(TCS_C_SCROLL, 4'h0);
         chk(32'(display_base), 32'((i % 23) * 80));
         apb(1'b0, TCS_SAVE_OFS, 32'h0);
         chk(32'(rd[20:16]), 32'(i % 23));
      end
   endtask

   task t_seq;
      for (int i = 0; i < 15; i++) begin
         cmd(TCS_C_OP_LD, 4'(i));
         chk(32'(operation_code_bits), 32'(i));
         chk(32'(op_code_15), 32'h0);
      end
      cmd(TCS_C_OP_LD, 4'hf);
      chk(32'(rd[19:16]), 32'he);
      chk(32'(rd[25:24]), 32'h2);
      cmd(TCS_C_STEP_LD, 4'h9);
      chk(32'(rd[23:20]), 32'h9);
      cmd(TCS_C_STEP_LD, 4'he);
      cmd(TCS_C_STEP, 4'h0);
      chk(32'(rd[23:20]), 32'h0);
      cmd(TCS_C_IDLE, 4'h0);
      cmd(TCS_C_STEP_LD, 4'h3);
      chk(32'(rd[25:20]), 32'h13);
   endtask

   task drain;
      int n;
      n = 0;
      while (tx_hold_occupied === 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(tx_hold_occupied), 32'h0);
   endtask

   task t_tx;
      far_slow <= 1'b1;
      inbuf_char <= 7'h00;
      sel(TCS_SRC_INBUF);
      cmd(TCS_C_TX_LD, 4'h0);
      chk(32'(tx_hold_occupied), 32'h0);
      inbuf_char <= 7'h41;
      cmd(TCS_C_TX_LD, 4'h0);
      chk(32'(tx_hold_occupied), 32'h1);
      chk(32'(tx_char), 32'h41);
      drain;
      apb(1'b1, TCS_CTRL_OFS, 32'h4);
      cmd(TCS_C_TX_LD, 4'h0);
      chk(32'(tx_hold_occupied), 32'h0);
      apb(1'b1, TCS_CTRL_OFS, 32'h1);
      key_char <= 7'h42;
      sel(TCS_SRC_KEY);
      cmd(TCS_C_TX_LD, 4'h0);
      chk(32'(tx_hold_occupied), 32'h0);
      apb(1'b1, TCS_CTRL_OFS, 32'h0);
      cmd(TCS_C_TX_LD, 4'h0);
      chk(32'(tx_char), 32'h42);
      far_slow <= 1'b0;
      drain;
   endtask

   task t_mem;
      mem_char <= 7'h33;
      sel(TCS_SRC_MEM);
      w0 = writes_seen;
      i0 = inserts_seen;
      cmd(TCS_C_WRITE, 4'h0);
      chk(32'(writes_seen - w0), 32'h1);
      chk(32'(inserts_seen - i0), 32'h0);
      chk(32'(last_wdata), 32'h33);
      apb(1'b1, TCS_CTRL_OFS, 32'h2);
      cmd(TCS_C_WRITE, 4'h0);
      chk(32'(inserts_seen - i0), 32'h1);
      apb(1'b1, TCS_CTRL_OFS, 32'h0);
   endtask

   task t_clk;
      count(40);
      chk(32'(n_main), 32'd10);
      apb(1'b1, TCS_DIV_OFS, 32'h0008_0004);
      repeat (40) @(posedge pclk);
      count(256);
      chk(32'(n_pri), 32'd64);
      chk(32'(n_aux), 32'd32);
      chk(32'(n_sel), 32'd64);
      chk(32'(n_baud), 32'd4);
      apb(1'b1, TCS_CTRL_OFS, 32'h8);
      repeat (40) @(posedge pclk);
      count(256);
      chk(32'(n_sel), 32'd32);
      chk(32'(n_baud), 32'd2);
      apb(1'b1, TCS_CTRL_OFS, 32'h0);
   endtask

   task t_kbreset;
      cmd(TCS_C_OP_LD, 4'h5);
      cmd(TCS_C_SCROLL, 4'h0);
      keypad_full_reset <= 1'b1;
      @(posedge pclk);
      keypad_full_reset <= 1'b0;
      apb(1'b0, TCS_STAT_OFS, 32'h0);
      chk(rd, 32'h0100_0000);
      chk(32'(display_base), 32'h0);
      apb(1'b0, TCS_SAVE_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, TCS_DIV_OFS, 32'h0);
      chk(rd, 32'h0008_0004);
   endtask

   initial begin
      #(25ns * 40000);
      fail_count++;
      close_out;
   end

   initial begin
      {presetn, psel, penable, pwrite, keypad_full_reset, far_slow} = '0;
      {paddr, pwdata} = '0;
      {inbuf_char, mem_char, delim_char, insdel_char, key_char} = '0;
      fail_count = 0;
      samples_checked = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_cursor;
      t_scroll;
      t_seq;
      t_tx;
      t_mem;
      t_clk;
      t_kbreset;
      close_out;
   end
endmodule // testbench
